// *** common/smi_pkg.sv ***
package smi_pkg;
  typedef struct packed {
    logic       zero15;
    logic [1:0] rsv14;
    logic       no_wait;
    logic       rsv11;
    logic       full_step;
    logic       low_squelch_select;
    logic       port_select;
    logic       wide_bus;
    logic       link_test_disable;
    logic [2:0] rsv5;
    logic [1:0] irq_pin_select;
    logic       rsv0;
  } smi_setup_s;
  typedef struct packed {
    logic [2:0] io_hi;
    logic [4:0] io_lo;
    logic [1:0] rom_size;
    logic [4:0] boot_rom_base_bits;
    logic       rsv0;
  } smi_base_s;
  typedef struct packed {
    logic [15:0] addr;
    logic        rd_n;
    logic        wr_n;
    logic [15:0] din;
  } smi_io_s;
  typedef enum logic [1:0] {
    SMI_W_IDLE = 2'b01,
    SMI_W_HOLD = 2'b10
  } smi_wait_e;
endpackage : smi_pkg

// *** common/smi_regs.svh ***
`ifndef SMI_REGS_SVH
`define SMI_REGS_SVH
// Register offsets and banks
`define SMI_OFF_SETUP 4'h0
`define SMI_OFF_BASE  4'h2
`define SMI_OFF_MINFO 4'h8
`define SMI_OFF_MCFG  4'ha
`define SMI_OFF_DATA  4'hc
`define SMI_OFF_BANK  4'he
`define SMI_BANK_MEM  3'h0
`define SMI_BANK_CFG  3'h1
`define SMI_BANK_DATA 3'h2
// Memory figures, units of 256 x M bytes
`define SMI_MEM_SIZE  8'h12
`define SMI_MULT_CODE 3'h1
`define SMI_MMU_RESET 3'h2
// Reset values
`define SMI_BASE_RST  16'h1867
`define SMI_RSV_LOW   3'h6
// Timing
`define SMI_CLK_NS    10
`define SMI_TICK_NS   50
`define SMI_DIV_CNT   (`SMI_TICK_NS / `SMI_CLK_NS)
`define SMI_WAIT_TICK 3'h3
// Boot ROM sizes
`define SMI_ROM_OFF   2'h0
`define SMI_ROM_16K   2'h1
`define SMI_ROM_32K   2'h2
`define SMI_ROM_64K   2'h3
`endif

// *** src/smi_io_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module smi_io_decode (
  input  wire logic [15:0]       io_addr,
  input  wire smi_pkg::smi_base_s base,
  input  wire logic [19:0]       mem_addr,
  input  wire logic              mem_read_n,
  output logic                   io_hit,
  output logic                   rom_hit
);
  function automatic logic rom_match(
    input smi_pkg::smi_base_s b, input logic [19:0] a);
    logic m;
    m = 1'b0;
    unique case (b.rom_size)
      `SMI_ROM_OFF: m = 1'b0;
      `SMI_ROM_16K: m = a[18:14] == b.boot_rom_base_bits;
      `SMI_ROM_32K: m = a[18:15] == b.boot_rom_base_bits[4:1];
      `SMI_ROM_64K: m = a[18:16] == b.boot_rom_base_bits[4:2];
    endcase
    return m;
  endfunction : rom_match

  // Full 64k decode down to a 16-location window
  assign io_hit = (io_addr[15:13] == base.io_hi) &&
                  (io_addr[9:5] == base.io_lo) &&
                  (io_addr[12:10] == 3'h0) && !io_addr[4];
  // Memory reads only, with A19 high
  assign rom_hit = !mem_read_n && mem_addr[19] &&
                   rom_match(base, mem_addr);
endmodule : smi_io_decode
`default_nettype wire

// *** src/smi_top.sv ***
// Overview of operation
// - Memory size field always reads 12h
// - Free memory resets to full size
// - Memory quantities in 256-byte units
// - Zero reservation: receive allocation never denied
// - Deny receive when free at most reservation
// - Reservation cleared by reset, kept by MMU reset
// - Bits 11..9 read-only multiplier code 001
// - Wait states unless no-wait, data port excepted
// - Full-step applies only with AUI selected
// - Squelch select: set 240mV, clear 400mV
// - Port select: set AUI, clear twisted pair
// - Bus width forced high by low strap
// - Link test off: link good, LED on
// - Link failed: status low, no cable data
// - Select one of four interrupt pins
// - Decode I/O base with zero gap bits
// - ROM size selects compared address bits
// - ROM hit on memory read, A19 high
// - Base register defaults 1867h, EEPROM loadable
// - Setup register loaded and stored by EEPROM
// - Soft reset keeps setup and base
// - MMU reset command restores free memory
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module smi_top (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire smi_pkg::smi_io_s  io,
  output logic [15:0]            io_dout_q,
  output logic                   io_doe_b_q,
  output logic                   iochrdy_q,
  input  wire logic [19:0]       mem_addr,
  input  wire logic              mem_read_n,
  output logic                   rom_sel_q,
  input  wire logic              data_not_ready,
  input  wire logic              wide_bus_strap_n,
  input  wire logic              soft_rst,
  input  wire logic              mmu_cmd_valid,
  input  wire logic [2:0]        mmu_cmd,
  input  wire logic [7:0]        alloc_pages,
  input  wire logic [7:0]        release_pages,
  output logic                   rx_deny_q,
  input  wire logic              ee_load,
  input  wire logic              ee_load_base,
  input  wire logic [15:0]       ee_word,
  output logic [15:0]            ee_setup_img_q,
  output logic [15:0]            ee_base_img_q,
  input  wire logic              link_fail,
  output logic                   link_good_q,
  output logic                   link_led_q,
  output logic                   link_pulse_en_q,
  output logic                   cable_tx_en_q,
  output logic                   aui_sel_q,
  output logic                   full_step_q,
  output logic                   low_squelch_q,
  output logic                   bus16_q,
  input  wire logic              irq_core,
  output logic [3:0]             irq_out_q,
  output logic [3:0]             irq_oe_b_q
);
  smi_pkg::smi_setup_s setup_q;
  smi_pkg::smi_base_s  base_q;
  logic [7:0]          free_q;
  logic [7:0]          reserve_q;
  logic [2:0]          bank_q;
  logic                acc_q;
  logic                io_hit;
  logic                rom_hit;
  logic                rdy;

  wire acc     = !io.rd_n || !io.wr_n;
  wire start   = acc && !acc_q && io_hit;
  wire wr_go   = start && !io.wr_n;
  wire [3:0] off = io.addr[3:0];
  wire mmu_rst = mmu_cmd_valid && (mmu_cmd == `SMI_MMU_RESET);
  wire strap_w = !wide_bus_strap_n;

  function automatic logic sel(input logic [2:0] b,
                               input logic [3:0] o,
                               input logic [2:0] wb,
                               input logic [3:0] wo);
    return (o == wo) && (o == `SMI_OFF_BANK || b == wb);
  endfunction : sel

  // Setup image with constant fields and strap forcing
  function automatic smi_pkg::smi_setup_s setup_fix(
    input smi_pkg::smi_setup_s s, input logic strap);
    smi_pkg::smi_setup_s r;
    r       = s;
    r.zero15 = 1'b0;
    r.rsv14  = 2'h0;
    r.rsv11  = 1'b0;
    r.rsv5   = `SMI_RSV_LOW;
    r.rsv0   = 1'b0;
    r.wide_bus = s.wide_bus || strap;
    return r;
  endfunction : setup_fix

  smi_pkg::smi_setup_s setup_rd;
  assign setup_rd = setup_fix(setup_q, strap_w);

  smi_io_decode u_dec (
    .io_addr    (io.addr),
    .base       (base_q),
    .mem_addr   (mem_addr),
    .mem_read_n (mem_read_n),
    .io_hit     (io_hit),
    .rom_hit    (rom_hit)
  );

  wire data_acc = acc && io_hit && bank_q == `SMI_BANK_DATA &&
                  off == `SMI_OFF_DATA;

  smi_wait_gen u_wait (
    .clk       (clk),
    .rst_b     (rst_b),
    .start     (start),
    .no_wait   (setup_q.no_wait),
    .data_hold (data_acc && data_not_ready),
    .rdy_q     (rdy)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) acc_q <= 1'b0;
    else acc_q <= acc;
  end

  // Bank select
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) bank_q <= `SMI_BANK_MEM;
    else if (soft_rst) bank_q <= `SMI_BANK_MEM;
    else if (wr_go && off == `SMI_OFF_BANK) bank_q <= io.din[2:0];
  end

  // Setup register: host write, EEPROM load, kept on soft reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_q      <= '0;
      setup_q.rsv5 <= `SMI_RSV_LOW;
    end else if (ee_load && !ee_load_base) begin
      setup_q <= setup_fix(smi_pkg::smi_setup_s'(ee_word), 1'b0);
    end else if (wr_go && sel(bank_q, off, `SMI_BANK_CFG,
                              `SMI_OFF_SETUP)) begin
      setup_q <= setup_fix(smi_pkg::smi_setup_s'(io.din), 1'b0);
    end
  end

  // Base register: defaults, EEPROM load, host write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_q <= smi_pkg::smi_base_s'(`SMI_BASE_RST);
    end else if (ee_load && ee_load_base) begin
      base_q <= smi_pkg::smi_base_s'(ee_word);
    end else if (wr_go && sel(bank_q, off, `SMI_BANK_CFG,
                              `SMI_OFF_BASE)) begin
      base_q <= smi_pkg::smi_base_s'(io.din);
    end
  end

  // Reservation for transmit, untouched by MMU reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) reserve_q <= 8'h0;
    else if (soft_rst) reserve_q <= 8'h0;
    else if (wr_go && sel(bank_q, off, `SMI_BANK_MEM,
                          `SMI_OFF_MCFG)) reserve_q <= io.din[7:0];
  end

  // Free pages, reloaded to full size
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) free_q <= `SMI_MEM_SIZE;
    else if (mmu_rst || soft_rst) free_q <= `SMI_MEM_SIZE;
    else free_q <= free_q - alloc_pages + release_pages;
  end

  // Receive allocation gate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rx_deny_q <= 1'b0;
    else rx_deny_q <= (reserve_q != 8'h0) && (free_q <= reserve_q);
  end

  // Read data path; unmapped offsets read zero
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0;
    if (sel(bank_q, off, `SMI_BANK_CFG, `SMI_OFF_SETUP))
      rd_word = setup_rd;
    else if (sel(bank_q, off, `SMI_BANK_CFG, `SMI_OFF_BASE))
      rd_word = base_q;
    else if (sel(bank_q, off, `SMI_BANK_MEM, `SMI_OFF_MINFO))
      rd_word = {`SMI_MEM_SIZE, free_q};
    else if (sel(bank_q, off, `SMI_BANK_MEM, `SMI_OFF_MCFG))
      rd_word = {4'h0, `SMI_MULT_CODE, 1'b0, reserve_q};
    else if (off == `SMI_OFF_BANK)
      rd_word = {13'h0, bank_q};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_dout_q  <= 16'h0;
      io_doe_b_q <= 1'b1;
    end else begin
      io_dout_q  <= rd_word;
      io_doe_b_q <= !(!io.rd_n && io_hit);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) iochrdy_q <= 1'b1;
    else iochrdy_q <= rdy && !(start && (!setup_q.no_wait || data_acc && data_not_ready));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rom_sel_q <= 1'b0;
    else rom_sel_q <= rom_hit;
  end

  // EEPROM store images
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ee_setup_img_q <= 16'h0;
      ee_base_img_q  <= `SMI_BASE_RST;
    end else begin
      ee_setup_img_q <= setup_rd;
      ee_base_img_q  <= base_q;
    end
  end

  // Network port and link controls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aui_sel_q       <= 1'b0;
      full_step_q     <= 1'b0;
      low_squelch_q   <= 1'b0;
      bus16_q         <= 1'b0;
      link_good_q     <= 1'b0;
      link_led_q      <= 1'b0;
      link_pulse_en_q <= 1'b0;
      cable_tx_en_q   <= 1'b0;
    end else begin
      aui_sel_q     <= setup_q.port_select;
      full_step_q   <= setup_q.full_step && setup_q.port_select;
      low_squelch_q <= setup_q.low_squelch_select;
      bus16_q       <= setup_rd.wide_bus;
      link_good_q     <= setup_q.link_test_disable || !link_fail;
      link_led_q      <= setup_q.link_test_disable || !link_fail;
      link_pulse_en_q <= !setup_q.link_test_disable;
      cable_tx_en_q   <= setup_q.link_test_disable || !link_fail;
    end
  end

  // One driven interrupt pin, others released
  for (genvar i = 0; i < 4; i++) begin : g_irq
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        irq_out_q[i]  <= 1'b0;
        irq_oe_b_q[i] <= (i != 0);
      end else begin
        irq_out_q[i]  <= (setup_q.irq_pin_select == 2'(i)) && irq_core;
        irq_oe_b_q[i] <= setup_q.irq_pin_select != 2'(i);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire minfo_rd = !io.rd_n && io_hit &&
                  sel(bank_q, off, `SMI_BANK_MEM, `SMI_OFF_MINFO);
  wire mcfg_rd  = !io.rd_n && io_hit &&
                  sel(bank_q, off, `SMI_BANK_MEM, `SMI_OFF_MCFG);

  property p_size;
    minfo_rd |=> io_dout_q[15:8] == `SMI_MEM_SIZE;
  endproperty
  a_size: assert property (p_size)
    else $error("memory size field wrong");

  property p_free_rst;
    mmu_rst |=> free_q == `SMI_MEM_SIZE;
  endproperty
  a_free_rst: assert property (p_free_rst)
    else $error("free memory not restored");

  property p_mult;
    mcfg_rd |=> io_dout_q[11:9] == `SMI_MULT_CODE &&
                io_dout_q[7:0] == $past(reserve_q);
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier code wrong");

  property p_no_deny;
    reserve_q == 8'h0 |=> !rx_deny_q;
  endproperty
  a_no_deny: assert property (p_no_deny)
    else $error("receive denied with zero reservation");

  property p_deny;
    reserve_q != 8'h0 && free_q <= reserve_q |=> rx_deny_q;
  endproperty
  a_deny: assert property (p_deny)
    else $error("receive not denied");

  property p_rsv_keep;
    mmu_rst && !soft_rst && !wr_go |=> $stable(reserve_q);
  endproperty
  a_rsv_keep: assert property (p_rsv_keep)
    else $error("reservation lost on MMU reset");

  sequence s_wait_go;
    start && !setup_q.no_wait;
  endsequence
  sequence s_wait_low;
    !iochrdy_q [*8];
  endsequence
  property p_wait;
    s_wait_go |=> s_wait_low;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait state too short");

  property p_step;
    full_step_q |-> aui_sel_q;
  endproperty
  a_step: assert property (p_step)
    else $error("full step without AUI");

  property p_bus16;
    !wide_bus_strap_n |=> bus16_q;
  endproperty
  a_bus16: assert property (p_bus16)
    else $error("bus width not forced");

  property p_link_off;
    setup_q.link_test_disable |=>
      link_good_q && link_led_q && cable_tx_en_q && !link_pulse_en_q;
  endproperty
  a_link_off: assert property (p_link_off)
    else $error("link test disable ignored");

  property p_link_fail;
    !setup_q.link_test_disable && link_fail |=>
      !link_good_q && !cable_tx_en_q;
  endproperty
  a_link_fail: assert property (p_link_fail)
    else $error("failed link still sends");

  property p_irq;
    $countones(~irq_oe_b_q) == 1;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin drive not one");

  property p_rom;
    rom_sel_q |-> !$past(mem_read_n) && $past(mem_addr[19]);
  endproperty
  a_rom: assert property (p_rom)
    else $error("ROM hit outside memory read");

  property p_soft;
    soft_rst && !ee_load && !wr_go |=>
      $stable(setup_q) && $stable(base_q);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset changed setup");
endmodule : smi_top
`default_nettype wire

// *** src/smi_wait_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module smi_wait_gen (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic no_wait,
  input  wire logic data_hold,
  output logic      rdy_q
);
  logic [2:0]        div_q;
  logic [2:0]        tick_q;
  logic              skip_q;
  smi_pkg::smi_wait_e st_q;
  wire tick     = (div_q == 3'(`SMI_DIV_CNT - 1));
  wire pre_tick = (div_q == 3'(`SMI_DIV_CNT - 2));

  // 20 MHz enable from the 100 MHz clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_q <= 3'h0;
    else if (tick) div_q <= 3'h0;
    else div_q <= div_q + 3'h1;
  end

  // Stretch 2-3 ticks, or only a busy data port when no_wait
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= smi_pkg::SMI_W_IDLE;
      rdy_q  <= 1'b1;
      tick_q <= 3'h0;
      skip_q <= 1'b0;
    end else begin
      unique case (st_q)
        smi_pkg::SMI_W_IDLE: if (start && (!no_wait || data_hold)) begin
          st_q   <= smi_pkg::SMI_W_HOLD;
          rdy_q  <= 1'b0;
          tick_q <= 3'h0;
          skip_q <= no_wait;
        end
        smi_pkg::SMI_W_HOLD: begin
          if (tick && tick_q != `SMI_WAIT_TICK) tick_q <= tick_q + 3'h1;
          // Leave a cycle before the last tick, the output flop adds one
          if ((skip_q || tick_q == `SMI_WAIT_TICK ||
               (pre_tick && tick_q == `SMI_WAIT_TICK - 3'h1)) && !data_hold) begin
            st_q  <= smi_pkg::SMI_W_IDLE;
            rdy_q <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : smi_wait_gen
`default_nettype wire

// *** tb/smi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module smi_host_model (
  input  wire logic             clk,
  input  wire logic             iochrdy_q,
  output var  smi_pkg::smi_io_s io,
  output var  logic [7:0]       wait_cnt
);
  initial begin
    io = '{addr: 16'h0000, rd_n: 1'b1, wr_n: 1'b1, din: 16'h0000};
    wait_cnt = 8'h00;
  end

  // Strobe held until ready is seen high, then released for a cycle
  task automatic bus_cycle(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    int n;
    n = 0;
    @(posedge clk);
    io.addr <= addr;
    io.din  <= data;
    io.rd_n <= wr;
    io.wr_n <= ~wr;
    @(posedge clk);
    @(negedge clk);
    while (iochrdy_q !== 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
    wait_cnt = n[7:0];
    @(posedge clk);
    io.rd_n <= 1'b1;
    io.wr_n <= 1'b1;
    io.din  <= ~data; // Released bus stops showing the old data
  endtask : bus_cycle
endmodule : smi_host_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module tb;
  logic             clk, rst_b, mem_read_n, data_not_ready, wide_bus_strap_n, soft_rst;
  logic             mmu_cmd_valid, ee_load, ee_load_base, link_fail, irq_core, prev_oe;
  logic [2:0]       mmu_cmd;
  logic [7:0]       alloc_pages, release_pages, wait_cnt;
  logic [15:0]      ee_word, io_base, w, r, exp, io_dout_q, ee_setup_img_q, ee_base_img_q;
  logic [19:0]      mem_addr;
  smi_pkg::smi_io_s io;
  logic             io_doe_b_q, iochrdy_q, rom_sel_q, rx_deny_q, link_good_q, link_led_q;
  logic             link_pulse_en_q, cable_tx_en_q, aui_sel_q, full_step_q, low_squelch_q;
  logic             bus16_q;
  logic [3:0]       irq_out_q, irq_oe_b_q;
  logic [15:0]      rd_q[$];
  logic [19:0]      rom_a[4] = '{20'hcc000, 20'hc8000, 20'hc4000, 20'h4c000};
  int               num_errors, checks_done, cycles;

  smi_top smi_top_inst (
    .clk(clk), .rst_b(rst_b), .io(io), .io_dout_q(io_dout_q), .io_doe_b_q(io_doe_b_q),
    .iochrdy_q(iochrdy_q), .mem_addr(mem_addr), .mem_read_n(mem_read_n),
    .rom_sel_q(rom_sel_q), .data_not_ready(data_not_ready),
    .wide_bus_strap_n(wide_bus_strap_n), .soft_rst(soft_rst),
    .mmu_cmd_valid(mmu_cmd_valid), .mmu_cmd(mmu_cmd), .alloc_pages(alloc_pages),
    .release_pages(release_pages), .rx_deny_q(rx_deny_q), .ee_load(ee_load),
    .ee_load_base(ee_load_base), .ee_word(ee_word), .ee_setup_img_q(ee_setup_img_q),
    .ee_base_img_q(ee_base_img_q), .link_fail(link_fail), .link_good_q(link_good_q),
    .link_led_q(link_led_q), .link_pulse_en_q(link_pulse_en_q),
    .cable_tx_en_q(cable_tx_en_q), .aui_sel_q(aui_sel_q), .full_step_q(full_step_q),
    .low_squelch_q(low_squelch_q), .bus16_q(bus16_q), .irq_core(irq_core),
    .irq_out_q(irq_out_q), .irq_oe_b_q(irq_oe_b_q)
  );
  smi_host_model host_inst (.clk(clk), .iochrdy_q(iochrdy_q), .io(io), .wait_cnt(wait_cnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected word at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected level at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_bit

  // Read data is compared on the first cycle the device drives the bus
  always @(negedge clk) begin
    if (io_doe_b_q === 1'b0 && prev_oe !== 1'b0) begin
      if (rd_q.size() == 0) begin
        num_errors++;
        $display("unexpected drive at %0t: got %h expected none", $time, io_dout_q);
      end else begin
        cmp_word(rd_q.pop_front(), io_dout_q);
      end
    end
    prev_oe = io_doe_b_q;
  end

  task automatic wr(input logic [3:0] off, input logic [15:0] d);
    host_inst.bus_cycle(1'b1, io_base | {12'h000, off}, d);
  endtask : wr

  task automatic rd(input logic [3:0] off, input logic [15:0] e);
    rd_q.push_back(e);
    host_inst.bus_cycle(1'b0, io_base | {12'h000, off}, 16'h0000);
  endtask : rd

  task automatic bank(input logic [2:0] b);
    wr(`SMI_OFF_BANK, {13'h0000, b});
  endtask : bank

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic pages(input logic [7:0] a, input logic [7:0] rl);
    @(posedge clk);
    alloc_pages   <= a;
    release_pages <= rl;
    @(posedge clk);
    alloc_pages   <= 8'h00;
    release_pages <= 8'h00;
    settle();
  endtask : pages

  task automatic mmu(input logic [2:0] c);
    @(posedge clk);
    mmu_cmd       <= c;
    mmu_cmd_valid <= 1'b1;
    @(posedge clk);
    mmu_cmd_valid <= 1'b0;
  endtask : mmu

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  initial begin
    {rst_b, data_not_ready, soft_rst, mmu_cmd_valid, ee_load, ee_load_base} = 6'h00;
    {link_fail, irq_core, mmu_cmd, alloc_pages, release_pages} = 21'h000000;
    {mem_read_n, wide_bus_strap_n, ee_word, mem_addr} = {2'h3, 16'h0000, 20'h00000};
    {io_base, prev_oe, num_errors, checks_done, cycles} = {16'h0300, 1'b1, 96'h0};
    void'($urandom(32'h62a4));
    do_reset();
    bank(`SMI_BANK_CFG);
    rd(`SMI_OFF_SETUP, 16'h0030);
    rd(`SMI_OFF_BASE, 16'h1867);
    bank(`SMI_BANK_MEM);
    wr(`SMI_OFF_MINFO, 16'h0000);
    rd(`SMI_OFF_MINFO, 16'h1212);
    rd(4'h4, 16'h0000);
    wr(`SMI_OFF_MCFG, 16'hfd05);
    rd(`SMI_OFF_MCFG, 16'h0205);
    pages(8'd12, 8'd0);
    cmp_bit(1'b0, rx_deny_q);
    wr(`SMI_OFF_MCFG, 16'h0005);
    pages(8'd1, 8'd0);
    cmp_bit(1'b1, rx_deny_q);
    pages(8'd0, 8'd1);
    cmp_bit(1'b0, rx_deny_q);
    wr(`SMI_OFF_MCFG, 16'h0000);
    pages(8'd6, 8'd0);
    cmp_bit(1'b0, rx_deny_q);
    rd(`SMI_OFF_MINFO, 16'h1200);
    wr(`SMI_OFF_MCFG, 16'h0005);
    settle();
    cmp_bit(1'b1, rx_deny_q);
    mmu(3'h3);
    rd(`SMI_OFF_MINFO, 16'h1200);
    mmu(3'h2);
    rd(`SMI_OFF_MINFO, 16'h1212);
    rd(`SMI_OFF_MCFG, 16'h0205);
    bank(`SMI_BANK_CFG);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      w = $urandom;
      r = $urandom;
      w[2:1] = i[1:0];
      wide_bus_strap_n <= i[1];
      link_fail        <= r[0];
      irq_core         <= r[1];
      wr(`SMI_OFF_SETUP, w);
      exp = (w & 16'h17c6) | 16'h0030 | (i[1] ? 16'h0000 : 16'h0080);
      rd(`SMI_OFF_SETUP, exp);
      settle();
      cmp_word(exp, ee_setup_img_q);
      cmp_bit(w[8], aui_sel_q);
      cmp_bit(w[10] & w[8], full_step_q);
      cmp_bit(w[9], low_squelch_q);
      cmp_bit(exp[7], bus16_q);
      cmp_word({12'h000, ~(4'h1 << i[1:0])}, {12'h000, irq_oe_b_q});
      cmp_bit(r[1], irq_out_q[i[1:0]]);
      cmp_bit(w[6] | ~r[0], link_good_q);
      cmp_bit(w[6] | ~r[0], cable_tx_en_q);
      cmp_bit(~w[6], link_pulse_en_q);
      if (w[6]) cmp_bit(1'b1, link_led_q);
      cmp_bit(1'b1, w[12] ? wait_cnt == 0 : wait_cnt >= 10 && wait_cnt <= 15);
    end
    wr(`SMI_OFF_SETUP, 16'h1000);
    bank(`SMI_BANK_DATA);
    data_not_ready <= 1'b1;
    fork
      begin
        repeat (8) @(posedge clk);
        data_not_ready <= 1'b0;
      end
    join_none
    wr(`SMI_OFF_DATA, 16'h00a5);
    cmp_bit(1'b1, wait_cnt != 0);
    wr(`SMI_OFF_DATA, 16'h005a);
    cmp_bit(1'b1, wait_cnt == 0);
    soft_rst <= 1'b1;
    repeat (2) @(posedge clk);
    soft_rst <= 1'b0;
    bank(`SMI_BANK_CFG);
    rd(`SMI_OFF_SETUP, 16'h1030);
    rd(`SMI_OFF_BASE, 16'h1867);
    wr(`SMI_OFF_BASE, 16'h1467);
    io_base = 16'h0280;
    rd(`SMI_OFF_BASE, 16'h1467);
    cmp_word(16'h1467, ee_base_img_q);
    host_inst.bus_cycle(1'b0, 16'h0292, 16'h0000);
    host_inst.bus_cycle(1'b0, 16'h1282, 16'h0000);
    host_inst.bus_cycle(1'b0, 16'h0302, 16'h0000);
    ee_load      <= 1'b1;
    ee_load_base <= 1'b1;
    ee_word      <= 16'h1867;
    @(posedge clk);
    ee_load <= 1'b0;
    io_base = 16'h0300;
    rd(`SMI_OFF_BASE, 16'h1867);
    ee_load      <= 1'b1;
    ee_load_base <= 1'b0;
    ee_word      <= 16'h0142;
    @(posedge clk);
    ee_load <= 1'b0;
    rd(`SMI_OFF_SETUP, 16'h0172);
    for (int sz = 0; sz < 4; sz++) begin
      wr(`SMI_OFF_BASE, {8'h18, sz[1:0], 5'b10011, 1'b0});
      for (int j = 0; j < 4; j++) begin
        mem_addr   <= rom_a[j];
        mem_read_n <= 1'b0;
        settle();
        cmp_bit(sz != 0 && sz >= j + 1, rom_sel_q);
        @(posedge clk);
      end
    end
    mem_addr   <= rom_a[0];
    mem_read_n <= 1'b1;
    settle();
    cmp_bit(1'b0, rom_sel_q);
    do_reset();
    bank(`SMI_BANK_MEM);
    rd(`SMI_OFF_MCFG, 16'h0200);
    settle();
    if (rd_q.size() != 0) begin
      num_errors++;
      $display("unexpected reads left at %0t: got %h expected %h", $time, rd_q.size(), 0);
    end
    stop_test();
  end
endmodule : tb
`default_nettype wire
